// *** sim/test_trs_sequencer.sv ***
/*
 * self-checking bench for the three-rail sequencer: power-up order, fault
 * fold-back, pwm latch timing and pump phases.
 * assumes the bench stands in for the analog comparators.
 */
`timescale 1ns/1ps
module test_trs_sequencer;
    import trs_pkg::*;
    // ****************************************************************
    // signals and counters
    // ****************************************************************
    localparam int SS_CYC    = 100;   // shortened soft-start ramp
    localparam int CYC_LIMIT = 40000; // hang ceiling, run needs ~12200
    logic        clk = 1'b0;          // 250 MHz oscillator
    logic        arst_n;              // shutdown from the host model
    logic        ref_good, main_good, main_in_reg, pwm_trip; // analog levels
    logic        neg_pump_up, neg_pump_ok, pos_pump_up, pos_pump_ok; // pump levels
    logic        ref_enable, boost_enable, boost_switch_node; // stage outputs
    logic [1:0]  neg_pump_drive, pos_pump_drive; // {pch, nch} pairs
    logic [15:0] pump_ramp_level;     // soft-start ceiling
    logic        power_good_n_o, power_good_n_oe, ready_line; // ready pin
    int          n_mismatch = 0;      // failed comparisons
    int          samples_checked = 0; // comparisons made
    int          cyc = 0;             // cycle count for the hang ceiling

    always #2 clk = ~clk; // 4 ns period

    trs_sequencer #(.SOFT_START_CYCLES(SS_CYC)) i_dut (
        .clk(clk), .arst_n(arst_n), .ref_good(ref_good), .main_good(main_good),
        .main_in_reg(main_in_reg), .neg_pump_up(neg_pump_up), .neg_pump_ok(neg_pump_ok),
        .pos_pump_up(pos_pump_up), .pos_pump_ok(pos_pump_ok), .pwm_trip(pwm_trip),
        .ref_enable(ref_enable), .boost_enable(boost_enable), .boost_switch_node(boost_switch_node),
        .neg_pump_drive(neg_pump_drive), .pos_pump_drive(pos_pump_drive),
        .pump_ramp_level(pump_ramp_level), .power_good_n_o(power_good_n_o),
        .power_good_n_oe(power_good_n_oe));

    trs_host_model i_host (.clk(clk), .pg_o(power_good_n_o), .pg_oe(power_good_n_oe),
        .shutdown_low_input_n(arst_n), .ready_line(ready_line));

    // ****************************************************************
    // helpers
    // ****************************************************************
    // observed bit selected by a small code, keeps the waits generic
    function automatic logic sig(input int k);
        case (k)
            0: sig = boost_enable;
            1: sig = neg_pump_drive[DRV_PCH_BIT];
            2: sig = neg_pump_drive[DRV_NCH_BIT];
            5: sig = boost_switch_node;
            6: sig = ready_line;
            7: sig = |neg_pump_drive;
            8: sig = |pos_pump_drive;
            default: sig = (pump_ramp_level === 16'hFFFF);
        endcase
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // bounded wait, n returns the edges spent
    task automatic wait_sig(input int k, input logic v, input int lim, output int n);
        n = 0;
        while (sig(k) !== v && n < lim) begin
            tick(1);
            n++;
        end
    endtask

    task automatic reach(input int k, input logic v, input int lim);
        int n;
        wait_sig(k, v, lim, n);
        chk(16'(sig(k)), 16'(v));
    endtask

    // exact edge count to the next change
    task automatic span(input int k, input logic v, input int exp);
        int n;
        wait_sig(k, v, exp + 5, n);
        chk(16'(n), 16'(exp));
    endtask

    // level must hold for every one of n cycles
    task automatic hold(input int k, input logic v, input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            tick(1);
            if (sig(k) !== v) bad = 1'b1;
        end
        chk(16'(bad), 16'h0000);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_off();
        chk(16'({ref_enable, boost_enable, boost_switch_node, neg_pump_drive, pos_pump_drive}), 16'h0000); // all off
        chk(pump_ramp_level | 16'(power_good_n_oe), 16'h0000); // ramp and ready off
        chk(16'(ready_line), 16'h0001); // ready released
    endtask

    task automatic t_seq();
        i_host.set_shutdown_low_input(1'b1);
        tick(1);
        chk(16'({ref_enable, boost_enable}), 16'h0002); // reference first
        hold(0, 1'b0, 50); // boost waits for reference
        {ref_good, main_good, neg_pump_ok, pos_pump_ok} = 4'hF;
        reach(0, 1'b1, 6); // boost after reference
        reach(5, 1'b1, 1006); // switching from the next period edge, no ramp
        hold(7, 1'b0, 2100); // negative pump waits
        main_in_reg = 1'b1;
        reach(10, 1'b1, SS_CYC + 10); // ramp done in time
        reach(7, 1'b1, 2010); // negative pump on
        hold(8, 1'b0, 2100); // positive pump waits
        neg_pump_up = 1'b1;
        reach(8, 1'b1, 2010); // positive pump on
        hold(6, 1'b1, 100); // ready waits for positive rail
        pos_pump_up = 1'b1;
        reach(6, 1'b0, 6); // ready pulled low
    endtask

    task automatic t_pump();
        reach(1, 1'b0, 1010); // leave any first half already running
        reach(1, 1'b1, 2010); // fresh first half begins
        tick(10);
        chk(16'({neg_pump_drive, pos_pump_drive}), 16'h0009); // first half phases
        span(1, 1'b0, 988); // half period length
        span(2, 1'b1, 2); // dead gap, then low side
        tick(10);
        chk(16'({neg_pump_drive, pos_pump_drive}), 16'h0006); // second half phases
        span(2, 1'b0, 988); // half period length
        span(1, 1'b1, 2); // full period 2000 cycles
    endtask

    task automatic t_pwm();
        pwm_trip = 1'b1;
        reach(5, 1'b0, 6); // trip clears the latch
        pwm_trip = 1'b0;
        reach(5, 1'b1, 1001); // next period sets it
        tick(100);
        pwm_trip = 1'b1;
        span(5, 1'b0, 3); // off three edges after trip
        pwm_trip = 1'b0;
        span(5, 1'b1, 897); // off till the fixed period ends
    endtask

    task automatic t_faults();
        {neg_pump_ok, neg_pump_up} = 2'h0;
        reach(6, 1'b1, 6); // ready released on pump fault
        reach(8, 1'b0, 6); // later stage stops
        chk(16'(boost_enable), 16'h0001); // boost keeps running
        reach(7, 1'b1, 2010); // negative pump still switching
        neg_pump_ok = 1'b1;
        hold(8, 1'b0, 2100); // no restart below power-up level
        neg_pump_up = 1'b1;
        reach(8, 1'b1, 2010); // resumes from the faulted stage
        reach(6, 1'b0, 12); // ready again
        {pos_pump_ok, pos_pump_up} = 2'h0;
        reach(6, 1'b1, 6); // positive fault releases ready
        reach(8, 1'b1, 2010); // positive pump keeps trying
        {pos_pump_ok, pos_pump_up} = 2'h3;
        reach(6, 1'b0, 12); // recovery
        {main_good, main_in_reg} = 2'h0;
        reach(6, 1'b1, 6); // boost fault releases ready
        reach(7, 1'b0, 6); // pumps stop
        chk(16'({boost_enable, pos_pump_drive}), 16'h0004); // boost stays, pos off
        main_good = 1'b1;
        hold(7, 1'b0, 50); // pumps wait for regulation again
        main_in_reg = 1'b1;
        reach(6, 1'b0, 20); // recovery
        ref_good = 1'b0;
        reach(0, 1'b0, 6); // reference fault stops boost
        reach(5, 1'b0, 6); // switch off with the boost
        chk(16'({ready_line, ref_enable}), 16'h0003); // released, reference kept
        ref_good = 1'b1;
        reach(6, 1'b0, 20); // recovery
    endtask

    task automatic t_restart();
        i_host.set_shutdown_low_input(1'b0);
        #1;
        t_off(); // shutdown acts at once
        i_host.set_shutdown_low_input(1'b1);
        tick(1);
        chk(16'({ref_enable, boost_enable}), 16'h0002); // restart from first step
        reach(6, 1'b0, 30); // full sequence again
    endtask

    // never both switches of a pump, plus the hang ceiling
    always @(posedge clk) begin
        #1;
        cyc++;
        chk(16'({&neg_pump_drive, &pos_pump_drive}), 16'h0000); // break before make
        if (cyc == CYC_LIMIT) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        {ref_good, main_good, main_in_reg, neg_pump_up, neg_pump_ok, pos_pump_up, pos_pump_ok, pwm_trip} = 8'h00;
        tick(20);
        t_off(); // held in shutdown
        t_seq();
        t_pump();
        t_pwm();
        t_faults();
        t_restart(); // shutdown mid-run
        finish_test();
    end
endmodule // test_trs_sequencer

// *** sim/trs_host_model.sv ***
/*
 * host side model: drives the shutdown input and reads the ready line.
 * assumes the ready pin is open drain with a pull-up kept at the host.
 */
`timescale 1ns/1ps
module trs_host_model (
    input  wire logic clk,        // oscillator clock
    input  wire logic pg_o,       // ready pin value from the sequencer
    input  wire logic pg_oe,      // ready pull-down on
    output logic      shutdown_low_input_n,     // shutdown_low_input to the sequencer
    output logic      ready_line  // resolved ready wire
);
    // pull-up wins whenever the pull-down is released
    assign ready_line = pg_oe ? pg_o : 1'b1;

    // defined from time zero, never left floating
    initial shutdown_low_input_n = 1'b0; // start in shutdown

    // level changes just after an edge, held until the next call
    task automatic set_shutdown_low_input(input logic v);
        @(posedge clk);
        #1 shutdown_low_input_n = v; // always a driven level
    endtask
endmodule // trs_host_model

// *** src/trs_pkg.sv ***
/*
 * constants for the three-rail power sequencer: timing figures, divider
 * counts and field positions of the pump drive pairs.
 * assumes a 250 MHz core clock that stands for the internal oscillator.
 */
package trs_pkg;
    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 250_000_000; // core clock rate
    localparam int unsigned BOOST_FREQ_HZ   = 250_000;     // boost switching rate
    localparam int unsigned PUMP_FREQ_HZ    = 125_000;     // pump switching rate
    localparam int unsigned SOFT_START_MS   = 16;          // pump regulation deadline
    // cycles per boost period
    localparam int unsigned BOOST_PERIOD_CYC = CLK_HZ / BOOST_FREQ_HZ;
    // cycles per pump half period (pump runs at half the boost rate)
    localparam int unsigned PUMP_HALF_CYC    = CLK_HZ / (2 * PUMP_FREQ_HZ);
    // soft-start ramp length in cycles (longest time, rounds down)
    localparam longint unsigned SOFT_START_CYC = longint'(CLK_HZ) / 1000 * SOFT_START_MS;
    localparam int unsigned DEAD_CYC         = 2;          // break-before-make gap
    localparam int unsigned SYNC_STAGES      = 2;          // synchroniser depth

    // ****************************************************************
    // drive pair field positions {pch, nch}
    // ****************************************************************
    localparam int unsigned DRV_NCH_BIT = 0;               // low-side enable
    localparam int unsigned DRV_PCH_BIT = 1;               // high-side enable
    localparam logic [1:0]  DRV_OFF     = 2'h0;            // both switches off

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        TRS_OFF,
        TRS_REF_UP,
        TRS_MAIN_UP,
        TRS_NEG_UP,
        TRS_POS_UP,
        TRS_READY
    } trs_state_t;
endpackage

// *** src/trs_sequencer.sv ***
/*
 * three-rail display supply sequencer: enable order, fault fold-back,
 * ready output, boost pwm latch and two-phase pump drive timing.
 * assumes analog comparator outputs arrive asynchronously, shutdown input
 * acts as the asynchronous reset, clk is the internal oscillator.
 */
// Summary of operation
// - shutdown low keeps every stage off
// - shutdown release starts sequence at first step
// - reference first, boost after reference good
// - negative pump after boost regulates
// - positive pump after negative pump power-up threshold
// - ready pulled low after positive pump threshold
// - any fault after ready releases ready
// - reference and boost undervoltage faults
// - negative and positive pump faults
// - fault stops later stages until recovery
// - earlier stages keep running during fault
// - boost runs on fixed 250kHz period
// - oscillator edge sets the pwm latch
// - comparator trip resets latch rest of period
// - pumps switch at half the boost rate
// - negative pump: pch then nch
// - positive pump: nch then pch
// - boost starts with no soft start
// - pumps ramp to regulation within 16ms
`timescale 1ns/1ps
module trs_sequencer
    import trs_pkg::*;
#(
    parameter longint unsigned SOFT_START_CYCLES = SOFT_START_CYC // ramp length, shortenable
) (
    input  wire logic       clk,                // internal oscillator clock
    input  wire logic       arst_n,             // shutdown_low_input, async active low
    input  wire logic       ref_good,           // reference above 1.05V
    input  wire logic       main_good,          // main_feedback above 1.1V fault level
    input  wire logic       main_in_reg,        // main boost regulation reached
    input  wire logic       neg_pump_up,        // neg_pump_feedback below 120mV
    input  wire logic       neg_pump_ok,        // neg_pump_feedback below 140mV
    input  wire logic       pos_pump_up,        // pos_pump_feedback above 1.125V
    input  wire logic       pos_pump_ok,        // pos_pump_feedback above 1.11V
    input  wire logic       pwm_trip,           // error/slope/current comparators tripped
    output logic            ref_enable,         // reference enable
    output logic            boost_enable,       // main boost enable
    output logic            boost_switch_node,  // boost switch gate drive
    output logic [1:0]      neg_pump_drive,     // {pch, nch} negative pump drive
    output logic [1:0]      pos_pump_drive,     // {pch, nch} positive pump drive
    output logic [15:0]     pump_ramp_level,    // soft-start ceiling, shared by pumps
    output logic            power_good_n_o,     // ready pin output value, always 0
    output logic            power_good_n_oe     // ready pull-down on
);
    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // refused at elaboration: values the counters cannot serve
    if (SOFT_START_CYCLES < 1) begin : g_chk_ss_min
        $error("soft start length must be at least one cycle");
    end
    // ramp product with 16'hFFFF must stay inside 64 bits
    if (SOFT_START_CYCLES > 64'h0000_FFFF_FFFF_FFFF) begin : g_chk_ss_max
        $error("soft start length too large for ramp arithmetic");
    end
    if (PUMP_HALF_CYC <= DEAD_CYC) begin : g_chk_dead
        $error("pump half period too short for dead time");
    end
    // pump period must be two boost periods to share the oscillator
    if (PUMP_HALF_CYC != BOOST_PERIOD_CYC) begin : g_chk_half
        $error("pump half period must equal the boost period");
    end

    localparam int unsigned BW = $clog2(BOOST_PERIOD_CYC);  // boost counter width
    localparam int unsigned PW = $clog2(2 * PUMP_HALF_CYC); // pump counter width

    // ****************************************************************
    // comparator synchronisers
    // ****************************************************************
    localparam int unsigned NCMP = 8;       // number of comparator inputs
    logic [NCMP-1:0] cmp_raw;               // raw comparator vector
    logic [NCMP-1:0] cmp_meta_r;            // first stage, read only by second
    logic [NCMP-1:0] cmp_sync_r;            // usable synchronised levels
    assign cmp_raw = {pwm_trip, pos_pump_ok, pos_pump_up, neg_pump_ok,
                      neg_pump_up, main_in_reg, main_good, ref_good};

    // two flops per comparator; metastable levels never reach the fsm
    // limitation: every level acts two cycles late, and a pulse
    // shorter than one clock may be missed altogether
    genvar gi;
    generate
        for (gi = 0; gi < NCMP; gi++) begin : g_sync
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    cmp_meta_r[gi] <= 1'b0;
                    cmp_sync_r[gi] <= 1'b0;
                end else begin
                    cmp_meta_r[gi] <= cmp_raw[gi];
                    cmp_sync_r[gi] <= cmp_meta_r[gi];
                end
            end
        end
    endgenerate

    logic s_ref_ok, s_main_ok, s_main_reg, s_neg_up, s_neg_ok, s_pos_up, s_pos_ok, s_trip;
    assign {s_trip, s_pos_ok, s_pos_up, s_neg_ok, s_neg_up, s_main_reg, s_main_ok, s_ref_ok} = cmp_sync_r;

    // ****************************************************************
    // sequencer state machine
    // ****************************************************************
    trs_state_t state_r;    // present sequence step
    trs_state_t state_nxt;  // next sequence step

    // fault fold-back: earlier stages stay, later ones stop
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TRS_OFF:     state_nxt = TRS_REF_UP;
            TRS_REF_UP:  if (s_ref_ok) state_nxt = TRS_MAIN_UP;
            TRS_MAIN_UP: begin
                // regulation alone would let a low fault level flap
                // between this step and the next, so both must agree
                if (!s_ref_ok)       state_nxt = TRS_REF_UP;
                else if (s_main_reg && s_main_ok) state_nxt = TRS_NEG_UP;
            end
            TRS_NEG_UP: begin
                if (!s_ref_ok)       state_nxt = TRS_REF_UP;
                else if (!s_main_ok) state_nxt = TRS_MAIN_UP;
                else if (s_neg_up)   state_nxt = TRS_POS_UP;
            end
            TRS_POS_UP: begin
                if (!s_ref_ok)       state_nxt = TRS_REF_UP;
                else if (!s_main_ok) state_nxt = TRS_MAIN_UP;
                else if (!s_neg_ok)  state_nxt = TRS_NEG_UP;
                else if (s_pos_up)   state_nxt = TRS_READY;
            end
            TRS_READY: begin
                if (!s_ref_ok)       state_nxt = TRS_REF_UP;
                else if (!s_main_ok) state_nxt = TRS_MAIN_UP;
                else if (!s_neg_ok)  state_nxt = TRS_NEG_UP;
                else if (!s_pos_ok)  state_nxt = TRS_POS_UP;
            end
            default:                 state_nxt = TRS_OFF;
        endcase
    end

    // reset is the shutdown pin; release restarts from the first step
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= TRS_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // stage enables follow the step directly
    logic neg_en, pos_en;   // pump run permissions
    always_comb begin
        ref_enable   = (state_r != TRS_OFF);
        boost_enable = (state_r == TRS_MAIN_UP) || (state_r == TRS_NEG_UP) ||
                       (state_r == TRS_POS_UP) || (state_r == TRS_READY);
        neg_en       = (state_r == TRS_NEG_UP) || (state_r == TRS_POS_UP) ||
                       (state_r == TRS_READY);
        pos_en       = (state_r == TRS_POS_UP) || (state_r == TRS_READY);
    end

    // ready pull-down is registered; released on any fold-back
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            power_good_n_oe <= 1'b0;
        end else begin
            power_good_n_oe <= (state_nxt == TRS_READY);
        end
    end
    assign power_good_n_o = 1'b0;   // open drain only ever pulls low

    // ****************************************************************
    // boost pwm
    // ****************************************************************
    logic [BW-1:0] boost_cnt_r;     // position within boost period
    logic          pwm_latch_r;     // set/reset switch latch
    logic          osc_edge;        // start of boost period

    // fixed-rate period counter, independent of load
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            boost_cnt_r <= '0;
        end else if (boost_cnt_r == BW'(BOOST_PERIOD_CYC - 1)) begin
            boost_cnt_r <= '0;
        end else begin
            boost_cnt_r <= boost_cnt_r + 1'b1;
        end
    end
    assign osc_edge = (boost_cnt_r == '0);

    // set by the period edge, reset by trip; no soft start ramp
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwm_latch_r <= 1'b0;
        end else if (!boost_enable) begin
            pwm_latch_r <= 1'b0;
        end else if (osc_edge) begin
            pwm_latch_r <= 1'b1;
        end else if (s_trip) begin
            pwm_latch_r <= 1'b0;
        end
    end
    assign boost_switch_node = pwm_latch_r;

    // ****************************************************************
    // charge pumps
    // ****************************************************************
    logic [PW-1:0] pump_cnt_r;      // position within pump period
    logic          first_half;      // first half-cycle window
    logic          second_half;     // second half-cycle window
    logic [1:0]    neg_nxt, pos_nxt;// next drive pairs

    // pump period is two boost periods, so it rides the same oscillator
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pump_cnt_r <= '0;
        end else if (pump_cnt_r == PW'(2 * PUMP_HALF_CYC - 1)) begin
            pump_cnt_r <= '0;
        end else begin
            pump_cnt_r <= pump_cnt_r + 1'b1;
        end
    end

    // dead time at the start of each half keeps pch and nch apart
    assign first_half  = (pump_cnt_r >= PW'(DEAD_CYC)) && (pump_cnt_r < PW'(PUMP_HALF_CYC));
    assign second_half = (pump_cnt_r >= PW'(PUMP_HALF_CYC + DEAD_CYC));

    always_comb begin
        neg_nxt = DRV_OFF;
        pos_nxt = DRV_OFF;
        if (neg_en) begin
            neg_nxt[DRV_PCH_BIT] = first_half;
            neg_nxt[DRV_NCH_BIT] = second_half;
        end
        if (pos_en) begin
            pos_nxt[DRV_NCH_BIT] = first_half;
            pos_nxt[DRV_PCH_BIT] = second_half;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            neg_pump_drive <= DRV_OFF;
            pos_pump_drive <= DRV_OFF;
        end else begin
            neg_pump_drive <= neg_nxt;
            pos_pump_drive <= pos_nxt;
        end
    end

    // soft start: ceiling ramps from zero to full over the ramp time;
    // shared by both pumps, restarts when the negative pump is (re)enabled and again on the step into the positive pump
    // delayed permission marks the step into the positive pump
    logic        pos_en_r;          // pos_en one cycle late
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pos_en_r <= 1'b0;
        end else begin
            pos_en_r <= pos_en;
        end
    end

    logic [63:0] ramp_cnt_r;        // cycles since pump enable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ramp_cnt_r <= '0;
        end else if (!neg_en || (pos_en && state_r == TRS_POS_UP && !pos_en_r)) begin
            ramp_cnt_r <= '0;
        end else if (ramp_cnt_r < SOFT_START_CYCLES) begin
            ramp_cnt_r <= ramp_cnt_r + 64'h1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pump_ramp_level <= 16'h0000;
        end else begin
            pump_ramp_level <= 16'((ramp_cnt_r * 64'hFFFF) / SOFT_START_CYCLES);
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_pump_no_overlap: assert property (@(posedge clk) disable iff (!arst_n)
        !(&neg_pump_drive) && !(&pos_pump_drive))
        else $error("pump switches overlap");
    a_ready_needs_pos: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(power_good_n_oe) |-> $past(s_pos_up))
        else $error("ready without positive pump threshold");
    a_fault_drops_ready: assert property (@(posedge clk) disable iff (!arst_n)
        (state_r == TRS_READY && !s_neg_ok && s_main_ok && s_ref_ok) |=> !power_good_n_oe)
        else $error("ready kept through fault");
    a_neg_fault_keeps: assert property (@(posedge clk) disable iff (!arst_n)
        (state_r == TRS_READY && !s_neg_ok && s_main_ok && s_ref_ok) |=> boost_enable ##1 pos_pump_drive == DRV_OFF)
        else $error("wrong stages after pump fault");
    a_boost_after_ref: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(boost_enable) |-> $past(s_ref_ok))
        else $error("boost before reference");
    a_neg_after_main: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(neg_en) && $past(state_r) == TRS_MAIN_UP |-> $past(s_main_reg))
        else $error("negative pump before regulation");
    a_latch_set_edge: assert property (@(posedge clk) disable iff (!arst_n)
        (osc_edge && boost_enable) |=> pwm_latch_r)
        else $error("latch not set at period edge");
    // a trip on the last count is overruled by the next period edge
    a_latch_trip_off: assert property (@(posedge clk) disable iff (!arst_n)
        (!osc_edge && s_trip && boost_cnt_r != BW'(BOOST_PERIOD_CYC - 1)) |=> !pwm_latch_r [*2])
        else $error("latch not reset by trip");
    a_sync_delay: assert property (@(posedge clk) disable iff (!arst_n)
        cmp_sync_r == $past(cmp_raw, 2) || !$past(arst_n) || !$past(arst_n, 2))
        else $error("synchroniser depth wrong");

    // positive pump only after the negative power-up level
    a_pos_after_neg: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(pos_en) |-> $past(s_neg_up))
        else $error("positive pump before negative threshold");
    // pumps must not switch while the negative pump is held off
    a_later_off_fault: assert property (@(posedge clk) disable iff (!arst_n)
        !neg_en |=> neg_pump_drive == DRV_OFF && pos_pump_drive == DRV_OFF)
        else $error("pump drive while stage held off");
    // boost switch dead from the cycle after the boost is disabled
    a_boost_gated: assert property (@(posedge clk) disable iff (!arst_n)
        !boost_enable |=> !boost_switch_node)
        else $error("boost switch on while disabled");
    // ready pull-down only while the whole sequence stands
    a_ready_only_done: assert property (@(posedge clk) disable iff (!arst_n)
        power_good_n_oe |-> state_r == TRS_READY)
        else $error("ready pulled low outside ready step");
    c_reach_ready: cover property (@(posedge clk) disable iff (!arst_n) $rose(power_good_n_oe));
    c_fault_fold: cover property (@(posedge clk) disable iff (!arst_n)
        state_r == TRS_READY ##1 state_r == TRS_NEG_UP);
    c_pwm_trip: cover property (@(posedge clk) disable iff (!arst_n) $fell(pwm_latch_r) && !osc_edge);

    // ****************************************************************
    // fold-back coverage
    // ****************************************************************
    c_main_fold: cover property (@(posedge clk) disable iff (!arst_n)
        state_r == TRS_READY ##1 state_r == TRS_MAIN_UP);
    c_ref_fold: cover property (@(posedge clk) disable iff (!arst_n)
        state_r == TRS_READY ##1 state_r == TRS_REF_UP);
endmodule // trs_sequencer
